// ### design/ring_fetch_consts.svh
/*
 * offsets, field positions, reset values and opcodes of the ring fetch block.
 * assumes it is included by bare name from the design files.
 */
`ifndef RING_FETCH_CONSTS_SVH
`define RING_FETCH_CONSTS_SVH
// ********************
// register offsets
// ********************
`define OFS_TAIL      8'h00
`define OFS_HEAD      8'h04
`define OFS_START     8'h08
`define OFS_CTL       8'h0c
`define OFS_PMODE     8'h10
// ********************
// field positions
// ********************
`define CTL_VALID     0
`define CTL_RPT_LO    1
`define CTL_RPT_HI    2
`define CTL_WAIT      10
`define CTL_LEN_LO    12
`define CTL_LEN_HI    20
`define CTL_WAIT_MASK 26
`define PMODE_MUTEX   0
`define TAIL_INUSE    0
`define OPC_HI        31
`define OPC_LO        29
`define IMODE_HI      1
`define IMODE_LO      0
`define ARB_ON_BIT    0
`define WAIT_COND_BIT 0
`define RPT64_BIT     14
`define RPT128_BIT    15
// ********************
// opcodes of the command dword
// ********************
`define OPC_NOP       3'h0
`define OPC_LAUNCH    3'h1
`define OPC_FINISH    3'h2
`define OPC_ARBGATE   3'h3
`define OPC_HOLD      3'h4
// ********************
// sizes and reset values
// ********************
`define PAGE_DW       19'h00400
`define UNMAPPED_RD   32'h00000000
`endif

// ### design/ring_fetch_pkg.sv
/*
 * types shared by the ring fetch block: fsm states and modes.
 * assumes ring_fetch_consts.svh holds the numbers.
 */
package ring_fetch_pkg;
  // parser states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD  = 4'b0010,
    ST_ADDR = 4'b0100,
    ST_HOLD = 4'b1000
  } state_t;
  // batch interruptibility
  typedef enum logic [1:0] {
    IM_ANY   = 2'h0,
    IM_CHAIN = 2'h1,
    IM_NONE  = 2'h2
  } imode_t;
  // head auto-report granularity
  typedef enum logic [1:0] {
    RPT_OFF = 2'h0,
    RPT_64K = 2'h1,
    RPT_128K = 2'h2
  } rpt_t;
endpackage : ring_fetch_pkg

// ### design/ring_batch_command_fetch.sv
/*
 * ring and batch command fetch: register port, ring head/tail walking,
 * batch launch and chaining, arbitration gate, hold-for-event waits.
 * assumes a memory that answers every one-cycle read request with one
 * memValid pulse later, and synchronous event/condition inputs.
 */
// The address-and-strobe port and the register offsets were chosen for this implementation.
// How it works
// - valid ring arbitrates, equal offsets mean empty
// - head reported at 64KB or 128KB crossings
// - mutex off: in-use reads zero, writes ignored
// - reading clear in-use sets it; write clears
// - batch launch fetches batch sequentially
// - batch end returns to next ring command
// - final launch in batch chains onward
// - arbitration gate toggles other sources
// - three interruptibility modes per launch
// - holding condition is no-op; event waits
// - waiting ring is treated as empty
// - wait flag set while ring waits
// - software cancel ends the wait
// - head advances per dword, back to zero at ring end
// - wrap count bumps on each head wrap
`timescale 1ns/100ps
`default_nettype none
`include "ring_fetch_consts.svh"
module ring_batch_command_fetch #(
  parameter int WRAP_W = 11                   // head wrap count width
) (
  // clock and reset
  input  wire  logic        core_clk,
  input  wire  logic        rst,
  // register port
  input  wire  logic [7:0]  regAddr,
  input  wire  logic [31:0] regWdata,
  input  wire  logic        regWr,
  input  wire  logic        regRd,
  output var   logic [31:0] regRdata_ff,
  // command memory read port
  output var   logic        memReq_ff,
  output var   logic [31:0] memAddr_ff,
  input  wire  logic        memValid,
  input  wire  logic [31:0] memData,
  // forwarded commands
  output var   logic        cmdValid_ff,
  output var   logic [31:0] cmdData_ff,
  // arbitration
  output var   logic        arbRequest_ff,
  output var   logic        arbGated_ff,
  output var   logic        preemptOk_ff,
  output var   logic [1:0]  batchMode_ff,
  // wait sources
  input  wire  logic        waitEvent,
  input  wire  logic        waitCond,
  // head auto-report
  output var   logic        reportValid_ff,
  output var   logic [31:0] reportData_ff
);
  // ********************
  // elaboration check
  // ********************
  if (WRAP_W < 1 || WRAP_W > 11) begin : g_bad_wrap
    $error("WRAP_W must lie in 1..11");
  end

  // ********************
  // state
  // ********************
  ring_fetch_pkg::state_t state_ff, nxt_state;   // parser fsm
  logic [18:0]       headDw_ff, nxt_headDw;     // head dword offset
  logic [WRAP_W-1:0] wrap_ff, nxt_wrap;         // head wrap count
  logic [17:0]       tailQw_ff, nxt_tailQw;     // tail qword offset
  logic              inUse_ff, nxt_inUse;       // ownership flag
  logic [19:0]       start_ff, nxt_start;       // buffer page base
  logic              valid_ff, nxt_valid;       // ring valid
  logic [1:0]        rpt_ff, nxt_rpt;           // report granularity
  logic [8:0]        lenPg_ff, nxt_lenPg;       // pages minus one
  logic              wait_ff, nxt_wait;         // ring wait flag
  logic              waitCondSel_ff, nxt_waitCondSel; // waiting on condition
  logic              mutexEn_ff, nxt_mutexEn;   // ring mutex enable
  logic              inBatch_ff, nxt_inBatch;   // executing a batch
  logic              srcBatch_ff, nxt_srcBatch; // fetch came from batch
  logic [31:0]       batchPtr_ff, nxt_batchPtr; // batch byte address
  logic [31:0]       nxt_rdata;
  logic              nxt_memReq;
  logic [31:0]       nxt_memAddr;
  logic              nxt_cmdValid;
  logic [31:0]       nxt_cmdData;
  logic              nxt_arbReq;
  logic              nxt_arbGated;
  logic              nxt_preempt;
  logic [1:0]        nxt_bmode;
  logic              nxt_rptValid;
  logic [31:0]       nxt_rptData;

  // ********************
  // helpers
  // ********************
  logic [19:0] lenDw;                           // ring length in dwords, 2MB needs 20 bits
  logic        ringEmpty;                       // head at tail qword
  logic [2:0]  opc;                             // opcode of fetched dword
  logic        cancel;                          // software wait cancel

  // length and emptiness
  always_comb begin
    lenDw = (20'(lenPg_ff) + 20'h1) * 20'(`PAGE_DW);
    ringEmpty = (headDw_ff[18:1] == tailQw_ff);
    opc = memData[`OPC_HI:`OPC_LO];
    cancel = regWr && (regAddr == `OFS_CTL) && regWdata[`CTL_WAIT_MASK]
             && !regWdata[`CTL_WAIT];
  end

  // ********************
  // next-state logic
  // ********************
  always_comb begin
    logic [18:0] hInc;
    logic        fetchRing;
    hInc = 19'h0;
    fetchRing = 1'b0;
    nxt_state = state_ff;
    nxt_headDw = headDw_ff;
    nxt_wrap = wrap_ff;
    nxt_tailQw = tailQw_ff;
    nxt_inUse = inUse_ff;
    nxt_start = start_ff;
    nxt_valid = valid_ff;
    nxt_rpt = rpt_ff;
    nxt_lenPg = lenPg_ff;
    nxt_wait = wait_ff;
    nxt_waitCondSel = waitCondSel_ff;
    nxt_mutexEn = mutexEn_ff;
    nxt_inBatch = inBatch_ff;
    nxt_srcBatch = srcBatch_ff;
    nxt_batchPtr = batchPtr_ff;
    nxt_rdata = `UNMAPPED_RD;
    nxt_memReq = 1'b0;
    nxt_memAddr = memAddr_ff;
    nxt_cmdValid = 1'b0;
    nxt_cmdData = cmdData_ff;
    nxt_arbGated = arbGated_ff;
    nxt_preempt = 1'b0;
    nxt_bmode = batchMode_ff;
    nxt_rptValid = 1'b0;
    nxt_rptData = reportData_ff;

    // parser fsm
    case (state_ff)
      ring_fetch_pkg::ST_IDLE: begin
        // batch first, else ring when it has work and is not held
        if (inBatch_ff) begin
          nxt_memReq = 1'b1;
          nxt_memAddr = batchPtr_ff;
          nxt_batchPtr = batchPtr_ff + 32'h4;
          nxt_srcBatch = 1'b1;
          nxt_state = ring_fetch_pkg::ST_CMD;
          // any-boundary batches may be preempted here
          nxt_preempt = !arbGated_ff
                        && batchMode_ff == ring_fetch_pkg::IM_ANY;
        end else if (valid_ff && !ringEmpty && !wait_ff) begin
          fetchRing = 1'b1;
          nxt_srcBatch = 1'b0;
          nxt_state = ring_fetch_pkg::ST_CMD;
          nxt_preempt = !arbGated_ff;
        end
      end
      ring_fetch_pkg::ST_CMD: begin
        // decode one fetched command dword
        if (memValid) begin
          nxt_state = ring_fetch_pkg::ST_IDLE;
          case (opc)
            `OPC_NOP: begin
              // padding, nothing to do
            end
            `OPC_LAUNCH: begin
              // fetch the batch address dword that follows
              nxt_bmode = memData[`IMODE_HI:`IMODE_LO];
              nxt_memReq = 1'b1;
              if (srcBatch_ff) begin
                nxt_memAddr = batchPtr_ff;
                nxt_batchPtr = batchPtr_ff + 32'h4;
              end else begin
                fetchRing = 1'b1;
              end
              nxt_state = ring_fetch_pkg::ST_ADDR;
            end
            `OPC_FINISH: begin
              // back to the ring; head already past the launch
              nxt_inBatch = 1'b0;
            end
            `OPC_ARBGATE: begin
              nxt_arbGated = !memData[`ARB_ON_BIT];
            end
            `OPC_HOLD: begin
              // a condition already present costs nothing
              if (!(memData[`WAIT_COND_BIT] && waitCond)) begin
                nxt_wait = 1'b1;
                nxt_waitCondSel = memData[`WAIT_COND_BIT];
                nxt_state = ring_fetch_pkg::ST_HOLD;
              end
            end
            default: begin
              // everything else goes downstream
              nxt_cmdValid = 1'b1;
              nxt_cmdData = memData;
            end
          endcase
        end
      end
      ring_fetch_pkg::ST_ADDR: begin
        // start or chain to the new batch
        if (memValid) begin
          nxt_batchPtr = {memData[31:2], 2'h0};
          nxt_inBatch = 1'b1;
          nxt_state = ring_fetch_pkg::ST_IDLE;
          // chain points allow preemption in chain mode
          nxt_preempt = srcBatch_ff && !arbGated_ff
                        && batchMode_ff == ring_fetch_pkg::IM_CHAIN;
        end
      end
      ring_fetch_pkg::ST_HOLD: begin
        // an event needs a fresh pulse, at least one cycle later
        if ((waitCondSel_ff ? waitCond : waitEvent) || cancel) begin
          nxt_wait = 1'b0;
          nxt_state = ring_fetch_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = ring_fetch_pkg::ST_IDLE;
      end
    endcase

    // ring fetch advances the head, wrapping at the end
    if (fetchRing) begin
      nxt_memReq = 1'b1;
      nxt_memAddr = {start_ff, 12'h0} + {11'h0, headDw_ff, 2'h0};
      hInc = headDw_ff + 19'h1;
      if ({1'b0, hInc} >= lenDw) begin
        nxt_headDw = 19'h0;
        nxt_wrap = wrap_ff + WRAP_W'(1);
      end else begin
        nxt_headDw = hInc;
      end
      // auto report on granularity crossing
      if ((rpt_ff == ring_fetch_pkg::RPT_64K
           && nxt_headDw[`RPT64_BIT] != headDw_ff[`RPT64_BIT])
          || (rpt_ff == ring_fetch_pkg::RPT_128K
           && nxt_headDw[`RPT128_BIT] != headDw_ff[`RPT128_BIT])) begin
        nxt_rptValid = 1'b1;
        nxt_rptData = 32'({nxt_wrap, nxt_headDw, 2'h0});
      end
    end

    // register reads
    if (regRd) begin
      if (regAddr == `OFS_TAIL) begin
        nxt_rdata = {11'h0, tailQw_ff, 2'h0, inUse_ff && mutexEn_ff};
        nxt_inUse = mutexEn_ff;
      end else if (regAddr == `OFS_HEAD) begin
        nxt_rdata = 32'({wrap_ff, headDw_ff, 2'h0});
      end else if (regAddr == `OFS_START) begin
        nxt_rdata = {start_ff, 12'h0};
      end else if (regAddr == `OFS_CTL) begin
        nxt_rdata = {11'h0, lenPg_ff, 1'b0, wait_ff, 7'h0, rpt_ff, valid_ff};
      end else if (regAddr == `OFS_PMODE) begin
        nxt_rdata = {31'h0, mutexEn_ff};
      end
    end

    // register writes
    if (regWr) begin
      if (regAddr == `OFS_TAIL) begin
        nxt_tailQw = regWdata[20:3];
        nxt_inUse = 1'b0;
      end else if (regAddr == `OFS_HEAD) begin
        nxt_headDw = regWdata[20:2];
        nxt_wrap = regWdata[20+WRAP_W:21];
      end else if (regAddr == `OFS_START) begin
        nxt_start = regWdata[31:12];
      end else if (regAddr == `OFS_CTL) begin
        nxt_valid = regWdata[`CTL_VALID];
        nxt_rpt = regWdata[`CTL_RPT_HI:`CTL_RPT_LO];
        nxt_lenPg = regWdata[`CTL_LEN_HI:`CTL_LEN_LO];
      end else if (regAddr == `OFS_PMODE) begin
        nxt_mutexEn = regWdata[`PMODE_MUTEX];
      end
    end

    // disabled mutex keeps the flag clear
    if (!nxt_mutexEn) begin
      nxt_inUse = 1'b0;
    end

    // arbitration request: valid, non-empty, not waiting
    nxt_arbReq = nxt_valid && !nxt_wait
                 && (nxt_headDw[18:1] != nxt_tailQw);
  end

  // ********************
  // registers
  // ********************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= ring_fetch_pkg::ST_IDLE;
      headDw_ff <= 19'h0;
      wrap_ff <= '0;
      tailQw_ff <= 18'h0;
      inUse_ff <= 1'b0;
      start_ff <= 20'h0;
      valid_ff <= 1'b0;
      rpt_ff <= 2'h0;
      lenPg_ff <= 9'h0;
      wait_ff <= 1'b0;
      waitCondSel_ff <= 1'b0;
      mutexEn_ff <= 1'b0;
      inBatch_ff <= 1'b0;
      srcBatch_ff <= 1'b0;
      batchPtr_ff <= 32'h0;
      regRdata_ff <= 32'h0;
      memReq_ff <= 1'b0;
      memAddr_ff <= 32'h0;
      cmdValid_ff <= 1'b0;
      cmdData_ff <= 32'h0;
      arbRequest_ff <= 1'b0;
      arbGated_ff <= 1'b0;
      preemptOk_ff <= 1'b0;
      batchMode_ff <= 2'h0;
      reportValid_ff <= 1'b0;
      reportData_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      headDw_ff <= nxt_headDw;
      wrap_ff <= nxt_wrap;
      tailQw_ff <= nxt_tailQw;
      inUse_ff <= nxt_inUse;
      start_ff <= nxt_start;
      valid_ff <= nxt_valid;
      rpt_ff <= nxt_rpt;
      lenPg_ff <= nxt_lenPg;
      wait_ff <= nxt_wait;
      waitCondSel_ff <= nxt_waitCondSel;
      mutexEn_ff <= nxt_mutexEn;
      inBatch_ff <= nxt_inBatch;
      srcBatch_ff <= nxt_srcBatch;
      batchPtr_ff <= nxt_batchPtr;
      regRdata_ff <= nxt_rdata;
      memReq_ff <= nxt_memReq;
      memAddr_ff <= nxt_memAddr;
      cmdValid_ff <= nxt_cmdValid;
      cmdData_ff <= nxt_cmdData;
      arbRequest_ff <= nxt_arbReq;
      arbGated_ff <= nxt_arbGated;
      preemptOk_ff <= nxt_preempt;
      batchMode_ff <= nxt_bmode;
      reportValid_ff <= nxt_rptValid;
      reportData_ff <= nxt_rptData;
    end
  end
endmodule : ring_batch_command_fetch
`default_nettype wire

// ### sim/ring_fetch_monitor.sv
/* port checker of the ring fetch block.
   assumes it is bound into ring_batch_command_fetch. */
`timescale 1ns/100ps
`default_nettype none
`include "ring_fetch_consts.svh"
module ring_fetch_monitor #(
  parameter int WRAP_W = 11  // head wrap count width
) (
  // clock, reset and register port
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata_ff,
  // memory port, outputs, wait source
  input wire logic        memReq_ff,
  input wire logic [31:0] memAddr_ff,
  input wire logic        memValid,
  input wire logic [31:0] memData,
  input wire logic        cmdValid_ff,
  input wire logic        arbGated_ff,
  input wire logic        preemptOk_ff,
  input wire logic [1:0]  batchMode_ff,
  input wire logic        reportValid_ff,
  input wire logic        waitEvent
);
  logic mutexOn_ff, pending_ff, addrNext_ff;     // mirrored state
  logic nxt_mutexOn, nxt_pending, nxt_addrNext;  // next values
  // ****
  // mirror of mutex, outstanding read, launch address phase
  // ****
  always_comb begin
    nxt_mutexOn = (regWr && regAddr == `OFS_PMODE) ? regWdata[`PMODE_MUTEX] : mutexOn_ff;
    nxt_pending = memReq_ff | (pending_ff & ~memValid);
    nxt_addrNext = memValid ? (memData[`OPC_HI:`OPC_LO] == `OPC_LAUNCH) : addrNext_ff;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mutexOn_ff <= 1'b0;
      pending_ff <= 1'b0;
      addrNext_ff <= 1'b0;
    end else begin
      mutexOn_ff <= nxt_mutexOn;
      pending_ff <= nxt_pending;
      addrNext_ff <= nxt_addrNext;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence tailRead;
    regRd && regAddr == `OFS_TAIL && mutexOn_ff;
  endsequence
  sequence launchAns;
    memValid && memData[`OPC_HI:`OPC_LO] == `OPC_LAUNCH;
  endsequence
  sequence holdEvtAns;
    memValid && memData[`OPC_HI:`OPC_LO] == `OPC_HOLD && !memData[`WAIT_COND_BIT];
  endsequence
  a_mutex_off_zero: assert property (regRd && regAddr == `OFS_TAIL && !mutexOn_ff |=> !regRdata_ff[0])
    else $error("in-use seen while mutex off");
  a_claim_sticks: assert property (tailRead ##1 !regWr ##1 tailRead |=> regRdata_ff[0])
    else $error("in-use not kept after claim");
  a_one_outstanding: assert property (memReq_ff |-> !pending_ff)
    else $error("second read while one outstanding");
  a_cmd_from_answer: assert property (cmdValid_ff |-> $past(memValid))
    else $error("command without memory answer");
  a_launch_addr_read: assert property (launchAns |=> memReq_ff)
    else $error("launch without address read");
  a_launch_target: assert property (memValid && addrNext_ff |-> ##2 memReq_ff && memAddr_ff == {$past(memData[31:2], 2), 2'b00})
    else $error("batch not fetched at its address");
  a_gate_no_preempt: assert property (arbGated_ff |-> !preemptOk_ff)
    else $error("preemption while gated");
  a_mode_legal: assert property (batchMode_ff != 2'h3)
    else $error("illegal batch mode");
  a_event_takes_time: assert property (holdEvtAns ##1 (!waitEvent && !regWr) |=> !memReq_ff)
    else $error("event wait ended at once");
  a_report_on_fetch: assert property (reportValid_ff |-> memReq_ff)
    else $error("report without fetch");
endmodule : ring_fetch_monitor
bind ring_batch_command_fetch ring_fetch_monitor #(.WRAP_W(WRAP_W)) mon (
  .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata_ff(regRdata_ff), .memReq_ff(memReq_ff),
  .memAddr_ff(memAddr_ff), .memValid(memValid), .memData(memData),
  .cmdValid_ff(cmdValid_ff), .arbGated_ff(arbGated_ff), .preemptOk_ff(preemptOk_ff),
  .batchMode_ff(batchMode_ff), .reportValid_ff(reportValid_ff), .waitEvent(waitEvent));
`default_nettype wire

// ### sim/cmd_memory_model.sv
/* command memory answering one read at a time.
   assumes the bench loads words and holds one request outstanding. */
`timescale 1ns/100ps
`default_nettype none
module cmd_memory_model (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // read port
  input wire logic        memReq,
  input wire logic [31:0] memAddr,
  input wire logic        slowMode,
  output var logic        memValid,
  output var logic [31:0] memData
);
  logic [31:0] words [0:4095];  // uncached command store
  logic [31:0] addr;            // held request address
  int          cnt;             // cycles left to answer
  initial begin
    foreach (words[i]) words[i] = 32'h0;
  end
  // answer after one or a few cycles; idle data keeps toggling
  always @(posedge core_clk) begin
    memValid <= 1'b0;
    memData <= rst ? 32'h0 : ~memData;  // idle bus shows the inverse
    if (rst) cnt <= 0;
    else if (memReq) begin
      addr <= memAddr;
      cnt <= slowMode ? 1 + int'($urandom % 4) : 1;
    end else if (cnt == 1) begin
      memValid <= 1'b1;
      memData <= words[addr[13:2]];
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule : cmd_memory_model
`default_nettype wire

// ### sim/tb.sv
/* self-checking bench of the ring fetch block.
   assumes the memory model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`include "ring_fetch_consts.svh"
module tb;
  logic        core_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [7:0]  regAddr = 8'h0;
  logic [31:0] regWdata = 32'h0, regRdata_ff, memAddr_ff, memData, cmdData_ff, reportData_ff;
  logic        memReq_ff, memValid, cmdValid_ff, arbRequest_ff, arbGated_ff, preemptOk_ff;
  logic        reportValid_ff, waitEvent = 1'b0, waitCond = 1'b0, slowMode = 1'b0, rdSeen = 1'b0;
  logic [1:0]  batchMode_ff;
  logic [31:0] expRd[$], expAddr[$], expCmd[$], expRpt[$];  // notes of expected results
  logic [31:0] fw [8];                                      // random forwarded commands
  int          failures = 0, totalChecks = 0;
  always #50 core_clk = ~core_clk;
  ring_batch_command_fetch dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_ff(regRdata_ff),
    .memReq_ff(memReq_ff), .memAddr_ff(memAddr_ff), .memValid(memValid), .memData(memData),
    .cmdValid_ff(cmdValid_ff), .cmdData_ff(cmdData_ff), .arbRequest_ff(arbRequest_ff),
    .arbGated_ff(arbGated_ff), .preemptOk_ff(preemptOk_ff), .batchMode_ff(batchMode_ff),
    .waitEvent(waitEvent), .waitCond(waitCond), .reportValid_ff(reportValid_ff),
    .reportData_ff(reportData_ff));
  cmd_memory_model mem (.core_clk(core_clk), .rst(rst), .memReq(memReq_ff),
    .memAddr(memAddr_ff), .slowMode(slowMode), .memValid(memValid), .memData(memData));
  // ****
  // checking and bus tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expRd.push_back(e);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
  endtask : rd
  task automatic expSeq(input logic [31:0] base, input int n);
    for (int i = 0; i < n; i++) expAddr.push_back(base + 32'(4 * i));
  endtask : expSeq
  // bounded wait for the arbitration request level
  task automatic waitArb(input logic v);
    for (int n = 0; n < 300 && arbRequest_ff !== v; n++) @(negedge core_clk);
    check(32'(arbRequest_ff), 32'(v));
  endtask : waitArb
  // bounded wait until the address, command and report notes are used and the ring is idle
  task automatic drain();
    for (int n = 0; n < 500 && (expAddr.size() + expCmd.size() + expRpt.size() > 0
         || arbRequest_ff !== 1'b0); n++) @(negedge core_clk);
    check(32'(expAddr.size() + expCmd.size() + expRpt.size()), 32'h0);
  endtask : drain
  // ****
  // watcher: oldest note against each result
  // ****
  always @(posedge core_clk) begin
    rdSeen <= regRd;
    if (rdSeen) check(regRdata_ff, expRd.pop_front());
    if (memReq_ff) check(memAddr_ff, expAddr.pop_front());
    if (cmdValid_ff) check(cmdData_ff, expCmd.pop_front());
    if (cmdValid_ff) check(32'(arbGated_ff), 32'(cmdData_ff == fw[2]));
    if (cmdValid_ff) check(batchMode_ff, {fw[3] == cmdData_ff, fw[2] == cmdData_ff});
    if (reportValid_ff) check(reportData_ff, expRpt.pop_front());
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    final_report();
  end
  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(32'h85ef));
    foreach (fw[i]) fw[i] = {3'h5 + 3'($urandom % 3), 29'($urandom)};
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    // reset values, unmapped place, in-use flag
    rd(`OFS_CTL, 32'h0);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h0);
    rd(`OFS_TAIL, 32'h0);
    rd(`OFS_TAIL, 32'h0);
    wr(`OFS_PMODE, 32'h1);
    rd(`OFS_TAIL, 32'h0);
    rd(`OFS_TAIL, 32'h1);
    wr(`OFS_TAIL, 32'h0);
    rd(`OFS_TAIL, 32'h0);
    rd(`OFS_TAIL, 32'h1);
    wr(`OFS_PMODE, 32'h0);
    rd(`OFS_TAIL, 32'h0);
    // ring launches a gated batch chaining twice, all three modes
    mem.words[0] = fw[0];
    mem.words[1] = {`OPC_LAUNCH, 29'h1};
    mem.words[2] = 32'h00002000;
    mem.words[3] = fw[1];
    mem.words[12'h800] = {`OPC_ARBGATE, 29'h0};
    mem.words[12'h801] = fw[2];
    mem.words[12'h802] = {`OPC_ARBGATE, 29'h1};
    mem.words[12'h803] = {`OPC_LAUNCH, 29'h2};
    mem.words[12'h804] = 32'h00003000;
    mem.words[12'hc00] = fw[3];
    mem.words[12'hc01] = {`OPC_LAUNCH, 29'h0};
    mem.words[12'hc02] = 32'h00003800;
    mem.words[12'he00] = {`OPC_FINISH, 29'h0};
    expSeq(32'h0, 3);
    expSeq(32'h2000, 5);
    expSeq(32'h3000, 3);
    expSeq(32'h3800, 1);
    expSeq(32'hc, 1);
    expCmd = '{fw[0], fw[2], fw[3], fw[1]};
    slowMode <= 1'($urandom % 2);
    wr(`OFS_START, 32'h0);
    wr(`OFS_HEAD, 32'h0);
    wr(`OFS_TAIL, 32'h10);
    wr(`OFS_CTL, 32'h1);
    drain();
    rd(`OFS_HEAD, 32'h10);
    // event wait, cancelled condition wait, condition already true
    mem.words[4] = {`OPC_HOLD, 29'h0};
    mem.words[5] = fw[4];
    mem.words[6] = {`OPC_HOLD, 29'h1};
    mem.words[7] = fw[5];
    mem.words[8] = {`OPC_HOLD, 29'h1};
    mem.words[9] = fw[6];
    expSeq(32'h10, 8);
    expCmd = '{fw[4], fw[5], fw[6]};
    slowMode <= 1'b1;
    wr(`OFS_TAIL, 32'h30);
    waitArb(1'b1);
    waitArb(1'b0);
    rd(`OFS_CTL, 32'h401);
    @(posedge core_clk);
    waitEvent <= 1'b1;
    @(posedge core_clk);
    waitEvent <= 1'b0;
    waitArb(1'b1);
    waitArb(1'b0);
    rd(`OFS_CTL, 32'h401);
    wr(`OFS_CTL, 32'h04000001);
    waitCond <= 1'b1;
    drain();
    rd(`OFS_CTL, 32'h1);
    waitCond <= 1'b0;
    // head report on a 64KB crossing, then a head wrap
    wr(`OFS_CTL, 32'h0);
    wr(`OFS_HEAD, 32'hfff8);
    wr(`OFS_TAIL, 32'h10000);
    expSeq(32'hfff8, 2);
    expRpt.push_back(32'h10000);
    wr(`OFS_CTL, 32'h1f003);
    drain();
    wr(`OFS_CTL, 32'h0);
    wr(`OFS_HEAD, 32'hff8);
    wr(`OFS_TAIL, 32'h0);
    expSeq(32'hff8, 2);
    wr(`OFS_CTL, 32'h1);
    drain();
    rd(`OFS_HEAD, 32'h200000);
    repeat (3) @(posedge core_clk);
    final_report();
  end
endmodule : tb
`default_nettype wire
